// file: bench/fdr_host_model.sv
// Serial host model: drives SCL and pulls SDA low, sixteen clocks per bit in steps of four clocks.
// Assumes a pull-up on SDA outside and a slave that samples SCL on clk.
`timescale 1ns/1ns
`include "fdr_defines.svh"
module fdr_host_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask

  // SDA moves only while SCL is low, so no false start or stop
  task automatic put(input logic b);
    sda_low <= ~b;
    w(4);
    scl <= 1'b1;
    w(8);
    scl <= 1'b0;
    w(4);
  endtask

  task automatic get(output logic b);
    sda_low <= 1'b0;
    w(4);
    scl <= 1'b1;
    w(4);
    b = sda;
    w(4);
    scl <= 1'b0;
    w(4);
  endtask

  // Serves as first and repeated start alike
  task automatic start;
    sda_low <= 1'b0;
    w(4);
    scl <= 1'b1;
    w(4);
    sda_low <= 1'b1;
    w(4);
    scl <= 1'b0;
    w(4);
  endtask

  task automatic stop;
    sda_low <= 1'b1;
    w(4);
    scl <= 1'b1;
    w(4);
    sda_low <= 1'b0;
    w(8);
  endtask

  task automatic tx(input logic [7:0] b, output logic ack);
    logic nak;
    for (int i = 7; i >= 0; i--) put(b[i]);
    get(nak);
    ack = ~nak;
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start;
    tx({`FDR_I2C_ADDR, 1'b0}, a0);
    tx(p, a1);
    tx(d, a2);
    stop;
    ok = a0 & a1 & a2;
  endtask

  task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start;
    tx({`FDR_I2C_ADDR, 1'b0}, a0);
    tx(p, a1);
    start;
    tx({`FDR_I2C_ADDR, 1'b1}, a2);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(1'b1);
    stop;
    ok = a0 & a1 & a2;
  endtask
endmodule

// file: bench/flash_driver_control_registers_tb.sv
// Self-checking bench of the flash driver control block over its serial port.
// Assumes the host model in fdr_host_model and a short flash tick.
`timescale 1ns/1ns
module flash_driver_control_registers_tb
  import fdr_pkg::*;
;
  localparam int TC = 8;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       strobe = 1'b0;
  logic       eoc = 1'b0;
  logic       ab_lo = 1'b0;
  logic       ab_hi = 1'b0;
  logic       scl, sda_low, sda_oe_n, flash_on, reduced, torch_on, charge_on;
  logic       ind_on, sen_en, stb_lvl, sda_out;
  logic [2:0] mode;
  logic [1:0] tgt;
  logic [7:0] torch_ma, fb_mv, cc;
  logic [9:0] oh_mv, sh_mv, sl_mv;
  wire        sda = ~(sda_low | ~sda_oe_n);
  int         error_cnt = 0;
  int         checks = 0;

  always #2 clk = ~clk;

  fdr_host_model u_fdr_host_model (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

  fdr_flash_ctrl #(.TICK_CYCLES(TC)) u_fdr_flash_ctrl (
    .CLK(clk), .RST_N(rst_n), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
    .STROBE(strobe), .EOC(eoc), .SENSE_ABOVE_LOW(ab_lo), .SENSE_ABOVE_HIGH(ab_hi),
    .MODE(mode), .FLASH_ON(flash_on), .FLASH_REDUCED(reduced), .TORCH_ON(torch_on),
    .CHARGE_ON(charge_on), .INDICATOR_ON(ind_on), .SENSE_ENABLE(sen_en),
    .STROBE_LEVEL(stb_lvl), .CHARGE_TARGET(tgt), .TORCH_MA(torch_ma), .FLASH_FB_MV(fb_mv),
    .OVERHEAD_MV(oh_mv), .CURRENT_CTRL(cc), .SENSE_HIGH_MV(sh_mv), .SENSE_LOW_MV(sl_mv));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_v(input logic [9:0] got, input logic [9:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp, input string m);
    chk_v({9'h000, got}, {9'h000, exp}, m);
  endtask

  task automatic wreg(input logic [7:0] p, input logic [7:0] d);
    logic ok;
    u_fdr_host_model.wr(p, d, ok);
    chk_b(ok, 1'b1, "write ack");
    @(negedge clk);
  endtask

  task automatic rreg(input logic [7:0] p, input logic [7:0] e);
    logic       ok;
    logic [7:0] d;
    u_fdr_host_model.rd(p, d, ok);
    chk_b(ok, 1'b1, "read ack");
    chk_v({2'h0, d}, {2'h0, e}, "read data");
    @(negedge clk);
  endtask

  // Edge trigger, then time for the answer to settle
  task automatic pulse;
    @(posedge clk);
    strobe <= 1'b1;
    @(posedge clk);
    strobe <= 1'b0;
    repeat (4) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rreg(8'h10, 8'h00);
    rreg(8'hb0, 8'h80);
    rreg(8'hd0, 8'hc6);
    rreg(8'hc0, 8'hf9);
    rreg(8'ha0, 8'hf8);
    rreg(8'h20, 8'h00);
    chk_v({2'h0, torch_ma}, 10'h03c, "torch");
    chk_v({2'h0, fb_mv}, 10'h064, "feedback");
    chk_b(sda_out, 1'b0, "sda drive level");
    chk_v(oh_mv, 10'h12c, "overhead");
    chk_v(sh_mv, 10'h388, "sense high");
    chk_v(sl_mv, 10'h05f, "sense low");
    chk_b(stb_lvl, 1'b1, "level");
    $display("test reset done");
  endtask

  task automatic t_mode;
    logic [2:0] k;
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      wreg(8'h10, {k[0], k[1], 1'b0, k[1:0], k});
      chk_v({7'h00, mode}, k[2] ? 10'h004 : {7'h00, k}, "mode");
      chk_b(torch_on, ~k[2] & k[0], "torch on");
      chk_b(charge_on, ~k[2] & k[1], "charge on");
      chk_v({8'h00, tgt}, {8'h00, k[1:0]}, "target");
      chk_b(ind_on, k[0], "indicator");
      chk_b(sen_en, k[1], "sense");
    end
    $display("test mode done");
  endtask

  task automatic t_level;
    logic [2:0] k;
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      wreg(8'ha0, {1'b0, k, 1'b0, k});
      wreg(8'hb0, {1'b0, k, 4'h0});
      chk_v({2'h0, torch_ma}, 10'h03c + 10'h014 * k, "torch");
      chk_v({2'h0, fb_mv}, 10'h01e + 10'h00a * k, "feedback");
      chk_v(oh_mv, 10'h12c + 10'h064 * k, "overhead");
      chk_v({2'h0, cc}, {3'h0, k, 1'b0, k}, "raw");
      chk_b(stb_lvl, 1'b0, "edge");
    end
    rreg(8'hb0, 8'h70);
    $display("test level done");
  endtask

  task automatic t_sense;
    wreg(8'hd0, 8'h15);
    rreg(8'hd0, 8'hd5);
    wreg(8'hc0, 8'h32);
    chk_v(sl_mv, 10'h14d, "sense low");
    chk_v(sh_mv, 10'h319, "sense high");
    $display("test sense done");
  endtask

  task automatic t_time(input logic [3:0] code, input int units);
    int n;
    n = 0;
    wreg(8'hb0, {4'h0, code});
    wreg(8'h10, 8'h24);
    @(posedge clk);
    strobe <= 1'b1;
    @(posedge clk);
    strobe <= 1'b0;
    for (int j = 0; j < 600; j++) begin
      @(negedge clk);
      if (flash_on === 1'b1) n++;
      else if (n > 0) break;
    end
    chk_b(n >= units * TC - 1 && n <= units * TC + 1, 1'b1, "length");
    rreg(8'h10, 8'h20);
    $display("test timeout done");
  endtask

  task automatic t_gate;
    wreg(8'hb0, 8'h0f);
    wreg(8'h10, 8'h04);
    pulse;
    chk_b(flash_on, 1'b0, "no charge");
    @(posedge clk);
    eoc <= 1'b1;
    pulse;
    chk_b(flash_on, 1'b1, "charged");
    wreg(8'h10, 8'h64);
    chk_b(flash_on, 1'b0, "cleared");
    @(posedge clk);
    ab_hi <= 1'b1;
    pulse;
    chk_b(flash_on, 1'b0, "above high");
    @(posedge clk);
    ab_hi <= 1'b0;
    ab_lo <= 1'b1;
    pulse;
    chk_b(flash_on, 1'b1, "above low");
    chk_b(reduced, 1'b1, "reduced");
    wreg(8'hb0, 8'h8f);
    wreg(8'h10, 8'h24);
    @(posedge clk);
    strobe <= 1'b1;
    repeat (4) @(negedge clk);
    chk_b(flash_on, 1'b1, "level on");
    chk_b(reduced, 1'b0, "sense off");
    @(posedge clk);
    strobe <= 1'b0;
    repeat (2) @(negedge clk);
    chk_b(flash_on, 1'b0, "level off");
    $display("test gate done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    $display("mismatch at %0t: watchdog", $time);
    conclude;
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(negedge clk);
    t_reset;
    t_mode;
    t_level;
    t_sense;
    t_time(4'h0, 1);
    t_time(4'h5, 6);
    t_time(4'hf, 32);
    t_gate;
    conclude;
  end
endmodule

// file: pkg/fdr_defines.svh
// Offsets, field positions, reset values and timing counts of the flash driver control block.
// Included by the src design files and the host model; holds definitions only.
`ifndef FDR_DEFINES_SVH
`define FDR_DEFINES_SVH

// Register offsets on the serial port
`define FDR_OFS_GP        8'h10
`define FDR_OFS_CC        8'ha0
`define FDR_OFS_OPT       8'hb0
`define FDR_OFS_SH        8'hc0
`define FDR_OFS_SL        8'hd0

// Power-on values
`define FDR_RST_GP        8'h00
`define FDR_RST_CC        8'hf8
`define FDR_RST_OPT       8'h80
`define FDR_RST_SH        8'hf9
`define FDR_RST_SL        8'hc6

// General purpose register fields
`define FDR_GP_TORCH      0
`define FDR_GP_CHARGE     1
`define FDR_GP_FLASH      2
`define FDR_GP_CM_LO      3
`define FDR_GP_CM_HI      4
`define FDR_GP_GATE       5
`define FDR_GP_SENSE_EN   6
`define FDR_GP_INDICATOR  7

// Current control fields (lowest bit of each 3-bit field)
`define FDR_CC_TORCH_LO   0
`define FDR_CC_FLASH_LO   4

// Options register fields
`define FDR_OPT_FD_LO     0
`define FDR_OPT_OH_LO     4
`define FDR_OPT_STROBE    7

// Sense-low fixed upper bits
`define FDR_SL_FIXED      2'h3

// Level encodings
`define FDR_TORCH_BASE_MA 8'h3c
`define FDR_TORCH_STEP_MA 8'h14
`define FDR_FB_BASE_MV    8'h1e
`define FDR_FB_STEP_MV    8'h0a
`define FDR_OH_BASE_MV    10'h12c
`define FDR_OH_STEP_MV    10'h064
`define FDR_SENSE_FS_MV   16'h03e8
`define FDR_SENSE_DIV     16'h003f

// Timing: flash timeout counts in 16 ms units; code 4'hf means 512 ms
`define FDR_TICK_MS       32'h10
`define FDR_CLK_KHZ       32'h3d090
`define FDR_TICK_CYCLES   (`FDR_TICK_MS * `FDR_CLK_KHZ)
`define FDR_FD_LONG_CODE  4'hf
`define FDR_FD_LONG_UNITS 6'h20

// Serial port address
`define FDR_I2C_ADDR      7'h53

`endif

// file: pkg/fdr_pkg.sv
// Types shared by the flash driver control block.
// No dependencies.
package fdr_pkg;

  typedef enum logic [2:0] {
    FDR_MODE_OFF       = 3'b000,
    FDR_MODE_TORCH     = 3'b001,
    FDR_MODE_CHARGE    = 3'b010,
    FDR_MODE_CHG_TORCH = 3'b011,
    FDR_MODE_FLASH     = 3'b100
  } fdr_mode_e;

  typedef enum logic {
    FDR_FL_IDLE = 1'b0,
    FDR_FL_ON   = 1'b1
  } fdr_flash_e;

  typedef enum logic [2:0] {
    FDR_I2C_IDLE = 3'b000,
    FDR_I2C_RX   = 3'b001,
    FDR_I2C_ACK  = 3'b010,
    FDR_I2C_TX   = 3'b011,
    FDR_I2C_RACK = 3'b100
  } fdr_i2c_e;

endpackage

// file: pkg/fdr_reg_if.sv
// Register access path between the serial slave and the register bank.
// Write strobe is one clock wide; read data is combinational from the address.
`timescale 1ns/1ns
interface fdr_reg_if;
  logic       wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport master (output wr, output addr, output wdata, input rdata);
  modport bank   (input wr, input addr, input wdata, output rdata);
endinterface

// file: src/fdr_flash_ctrl.sv
// Control and configuration register bank of a super-capacitor flash LED driver,
// with mode decode and the flash strobe, gate, sense and timeout sequencing.
// Assumes a serial host on SCL/SDA and analog comparators and charger outside.
`timescale 1ns/1ns
`include "fdr_defines.svh"

// Function
// - Flash bit wins; else charge and torch bits select off, torch, charge or both.
// - Charge-mode field picks optimal, 4.5 V, 5.0 V or 5.3 V target.
// - With flash gate clear, no flash starts before end of charge.
// - With flash gate set, a flash may start before end of charge.
// - Sense enable bit turns ambient or thermal sensing off or on.
// - Indicator enable bit switches the indicator current source.
// - Torch code maps to 60 mA plus 20 mA per step.
// - Flash code maps to 30 mV feedback plus 10 mV per step.
// - Options: strobe sensitivity bit 7, overhead bits 6:4, duration bits 3:0.
// - Strobe sensitivity 0 means edge, 1 means level.
// - Timeout is 16 ms times code plus one; top code gives 512 ms.
// - Overhead code maps to 300 mV plus 100 mV per step.
// - Sense-low reads ones in bits 7:6, threshold in bits 5:0.
// - Each trip level is one volt times code over 63.
// - General purpose holds mode bits 2:0, charge mode 4:3, gate 5.
// - Sensing on and above low threshold cuts flash to 70 percent.
// - Sensing on and above high threshold blocks a flash start.
module fdr_flash_ctrl
  import fdr_pkg::*;
#(
  parameter int         TICK_CYCLES = `FDR_TICK_CYCLES,
  parameter logic [6:0] DEV_ADDR    = `FDR_I2C_ADDR
) (
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic       SCL,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE_N,
  input  wire logic       STROBE,
  input  wire logic       EOC,
  input  wire logic       SENSE_ABOVE_LOW,
  input  wire logic       SENSE_ABOVE_HIGH,
  output logic [2:0]      MODE,
  output logic            FLASH_ON,
  output logic            FLASH_REDUCED,
  output logic            TORCH_ON,
  output logic            CHARGE_ON,
  output logic            INDICATOR_ON,
  output logic            SENSE_ENABLE,
  output logic            STROBE_LEVEL,
  output logic [1:0]      CHARGE_TARGET,
  output logic [7:0]      TORCH_MA,
  output logic [7:0]      FLASH_FB_MV,
  output logic [9:0]      OVERHEAD_MV,
  output logic [7:0]      CURRENT_CTRL,
  output logic [9:0]      SENSE_HIGH_MV,
  output logic [9:0]      SENSE_LOW_MV
);

  fdr_reg_if rb ();

  //////////////////////////////////////////////////////////////////////////////
  // Serial port and timebase

  logic tick;
  logic fl_start;

  fdr_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_i2c (
    .clk      (CLK),
    .rst_n    (RST_N),
    .scl      (SCL),
    .sda      (SDA_IN),
    .sda_oe_n (SDA_OE_N),
    .rb       (rb)
  );

  // Restart aligns the first 16 ms unit with the flash start
  fdr_tick_div #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk     (CLK),
    .rst_n   (RST_N),
    .restart (fl_start),
    .tick    (tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Register bank

  logic [7:0] gp;
  logic [7:0] cc;
  logic [7:0] opt;
  logic [7:0] sh;
  logic [5:0] sl;

  wire wr_gp  = rb.wr && (rb.addr == `FDR_OFS_GP);
  wire wr_cc  = rb.wr && (rb.addr == `FDR_OFS_CC);
  wire wr_opt = rb.wr && (rb.addr == `FDR_OFS_OPT);
  wire wr_sh  = rb.wr && (rb.addr == `FDR_OFS_SH);
  wire wr_sl  = rb.wr && (rb.addr == `FDR_OFS_SL);

  assign rb.rdata = (rb.addr == `FDR_OFS_GP)  ? gp  :
                    (rb.addr == `FDR_OFS_CC)  ? cc  :
                    (rb.addr == `FDR_OFS_OPT) ? opt :
                    (rb.addr == `FDR_OFS_SH)  ? sh  :
                    (rb.addr == `FDR_OFS_SL)  ? {`FDR_SL_FIXED, sl} : 8'h00;

  wire       b_torch          = gp[`FDR_GP_TORCH];
  wire       b_charge         = gp[`FDR_GP_CHARGE];
  wire       b_flash          = gp[`FDR_GP_FLASH];
  wire [1:0] cmode            = gp[`FDR_GP_CM_HI:`FDR_GP_CM_LO];
  wire       flash_gate       = gp[`FDR_GP_GATE];
  wire       sense_en         = gp[`FDR_GP_SENSE_EN];
  wire       indicator_enable = gp[`FDR_GP_INDICATOR];

  wire       strobe_sensitivity = opt[`FDR_OPT_STROBE];
  wire [2:0] oh                 = opt[`FDR_OPT_OH_LO +: 3];
  wire [3:0] fd                 = opt[`FDR_OPT_FD_LO +: 4];

  wire [2:0] tcode = cc[`FDR_CC_TORCH_LO +: 3];
  wire [2:0] fcode = cc[`FDR_CC_FLASH_LO +: 3];

  //////////////////////////////////////////////////////////////////////////////
  // Flash sequencing

  fdr_flash_e fl_state;
  logic       strobe_q;
  logic [5:0] units;

  wire strobe_rise = STROBE && !strobe_q;
  wire trig        = strobe_sensitivity ? STROBE : strobe_rise;
  wire sense_hot   = sense_en && SENSE_ABOVE_HIGH;
  wire charge_ok   = flash_gate || EOC;
  assign fl_start  = (fl_state == FDR_FL_IDLE) && b_flash && trig && charge_ok && !sense_hot;

  // timeout length in 16 ms units
  wire [5:0] limit   = (fd == `FDR_FD_LONG_CODE) ? `FDR_FD_LONG_UNITS : {2'h0, fd} + 6'h01;
  wire       expire  = (fl_state == FDR_FL_ON) && tick && (units == limit - 6'h01);
  // level mode ends when strobe drops
  wire       lvl_end = (fl_state == FDR_FL_ON) && strobe_sensitivity && !STROBE;
  wire       fl_stop = expire || lvl_end || ((fl_state == FDR_FL_ON) && !b_flash);

  fdr_flash_e next_fl_state;
  assign next_fl_state = fl_start ? FDR_FL_ON : (fl_stop ? FDR_FL_IDLE : fl_state);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fl_state <= FDR_FL_IDLE;
      strobe_q <= 1'b0;
      units    <= 6'h00;
    end else begin
      fl_state <= next_fl_state;
      strobe_q <= STROBE;
      units    <= fl_start ? 6'h00 : (tick ? units + 6'h01 : units);
    end
  end

  // timeout clears the flash bit; a host write that cycle wins
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      gp  <= `FDR_RST_GP;
      cc  <= `FDR_RST_CC;
      opt <= `FDR_RST_OPT;
      sh  <= `FDR_RST_SH;
      sl  <= 6'(`FDR_RST_SL);
    end else begin
      if (wr_gp) begin
        gp <= rb.wdata;
      end else if (expire) begin
        gp[`FDR_GP_FLASH] <= 1'b0;
      end
      if (wr_cc)  cc  <= rb.wdata;
      if (wr_opt) opt <= rb.wdata;
      if (wr_sh)  sh  <= rb.wdata;
      if (wr_sl)  sl  <= rb.wdata[5:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decode and registered outputs

  fdr_mode_e mode;
  assign mode = b_flash ? FDR_MODE_FLASH : fdr_mode_e'({1'b0, b_charge, b_torch});

  function automatic logic [9:0] trip_mv(input logic [5:0] n);
    logic [15:0] p;
    p = ({10'h000, n} * `FDR_SENSE_FS_MV) / `FDR_SENSE_DIV;
    return p[9:0];
  endfunction

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      MODE <= FDR_MODE_OFF;
      FLASH_ON <= 1'b0;
      FLASH_REDUCED <= 1'b0;
      TORCH_ON <= 1'b0;
      CHARGE_ON <= 1'b0;
      INDICATOR_ON <= 1'b0;
      SENSE_ENABLE <= 1'b0;
      STROBE_LEVEL <= 1'b0;
      CHARGE_TARGET <= 2'h0;
      TORCH_MA <= 8'h00;
      FLASH_FB_MV <= 8'h00;
      OVERHEAD_MV <= 10'h000;
      CURRENT_CTRL <= 8'h00;
      SENSE_HIGH_MV <= 10'h000;
      SENSE_LOW_MV <= 10'h000;
      SDA_OUT <= 1'b0;
    end else begin
      MODE <= mode;
      FLASH_ON <= (next_fl_state == FDR_FL_ON);
      TORCH_ON <= (mode == FDR_MODE_TORCH) || (mode == FDR_MODE_CHG_TORCH);
      CHARGE_ON <= (mode == FDR_MODE_CHARGE) || (mode == FDR_MODE_CHG_TORCH);
      FLASH_REDUCED <= sense_en && SENSE_ABOVE_LOW;
      INDICATOR_ON <= indicator_enable;
      SENSE_ENABLE <= sense_en;
      STROBE_LEVEL <= strobe_sensitivity;
      CHARGE_TARGET <= cmode;
      TORCH_MA <= `FDR_TORCH_BASE_MA + {5'h00, tcode} * `FDR_TORCH_STEP_MA;
      FLASH_FB_MV <= `FDR_FB_BASE_MV + {5'h00, fcode} * `FDR_FB_STEP_MV;
      OVERHEAD_MV <= `FDR_OH_BASE_MV + {7'h00, oh} * `FDR_OH_STEP_MV;
      CURRENT_CTRL <= cc;
      SENSE_HIGH_MV <= trip_mv(sh[5:0]);
      SENSE_LOW_MV <= trip_mv(sl);
      SDA_OUT <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_idle_armed;
    (fl_state == FDR_FL_IDLE) && b_flash && trig && !sense_hot;
  endsequence

  sequence s_expiry;
    expire && !wr_gp;
  endsequence

  property p_mode_flash;
    @(posedge CLK) disable iff (!RST_N)
    b_flash |=> (MODE == FDR_MODE_FLASH) && !TORCH_ON && !CHARGE_ON;
  endproperty
  a_mode_flash: assert property (p_mode_flash) else $error("flash bit not dominant");

  property p_mode_cht;
    @(posedge CLK) disable iff (!RST_N)
    (!b_flash && b_charge && b_torch) |=> (MODE == FDR_MODE_CHG_TORCH) && TORCH_ON && CHARGE_ON;
  endproperty
  a_mode_cht: assert property (p_mode_cht) else $error("charge and torch decode wrong");

  property p_charge_target;
    @(posedge CLK) disable iff (!RST_N)
    ##1 CHARGE_TARGET == $past(gp[4:3]);
  endproperty
  a_charge_target: assert property (p_charge_target) else $error("charge target wrong");

  property p_gate_block;
    @(posedge CLK) disable iff (!RST_N)
    ((fl_state == FDR_FL_IDLE) && !flash_gate && !EOC) |=> !FLASH_ON;
  endproperty
  a_gate_block: assert property (p_gate_block) else $error("flash began before charge end");

  property p_gate_open;
    @(posedge CLK) disable iff (!RST_N)
    (s_idle_armed and (flash_gate && !EOC)) |=> FLASH_ON;
  endproperty
  a_gate_open: assert property (p_gate_open) else $error("gated flash did not start");

  property p_sense_off;
    @(posedge CLK) disable iff (!RST_N)
    !sense_en |=> !FLASH_REDUCED && !SENSE_ENABLE;
  endproperty
  a_sense_off: assert property (p_sense_off) else $error("sensing active while off");

  property p_indicator;
    @(posedge CLK) disable iff (!RST_N)
    ##1 INDICATOR_ON == $past(indicator_enable);
  endproperty
  a_indicator: assert property (p_indicator) else $error("indicator not following bit");

  property p_torch_ma;
    @(posedge CLK) disable iff (!RST_N)
    (tcode == 3'h7) |=> (TORCH_MA == 8'hc8);
  endproperty
  a_torch_ma: assert property (p_torch_ma) else $error("torch top code not 200 mA");

  property p_sl_read;
    @(posedge CLK) disable iff (!RST_N)
    (rb.addr == `FDR_OFS_SL) |-> (rb.rdata[7:6] == 2'h3) && (rb.rdata[5:0] == sl);
  endproperty
  a_sl_read: assert property (p_sl_read) else $error("sense-low readback wrong");

  property p_timeout;
    @(posedge CLK) disable iff (!RST_N)
    s_expiry |=> !FLASH_ON && !b_flash && (fl_state == FDR_FL_IDLE);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not end flash");

  property p_hot_block;
    @(posedge CLK) disable iff (!RST_N)
    ((fl_state == FDR_FL_IDLE) && sense_hot) |=> (fl_state == FDR_FL_IDLE);
  endproperty
  a_hot_block: assert property (p_hot_block) else $error("flash started above high trip");

  property p_edge_only;
    @(posedge CLK) disable iff (!RST_N)
    ((fl_state == FDR_FL_IDLE) && !strobe_sensitivity && !strobe_rise) |=>
      (fl_state == FDR_FL_IDLE);
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("edge mode started without edge");

  property p_level_end;
    @(posedge CLK) disable iff (!RST_N)
    ((fl_state == FDR_FL_ON) && strobe_sensitivity && !STROBE && !fl_start) |=>
      !FLASH_ON ##1 (!FLASH_ON || $past(STROBE));
  endproperty
  a_level_end: assert property (p_level_end) else $error("level flash outlived strobe");

endmodule

// file: src/fdr_i2c_slave.sv
// Serial register port slave: address byte, register pointer, then data bytes.
// SCL and SDA are taken as synchronous to clk; SDA is open drain.
`timescale 1ns/1ns
`include "fdr_defines.svh"
module fdr_i2c_slave
  import fdr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `FDR_I2C_ADDR
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_oe_n,
  fdr_reg_if.master rb
);
  fdr_i2c_e   st;
  logic       scl_q;
  logic       sda_q;
  logic       rd;
  logic [3:0] bitcnt;
  logic [1:0] byte_n;
  logic [7:0] shreg;
  logic [7:0] ptr;

  wire scl_rise = scl && !scl_q;
  wire scl_fall = !scl && scl_q;
  wire start    = scl && scl_q && sda_q && !sda;
  wire stop     = scl && scl_q && !sda_q && sda;
  wire addr_hit = (shreg[7:1] == DEV_ADDR);

  assign rb.addr  = ptr;
  assign rb.wdata = shreg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= FDR_I2C_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rd <= 1'b0;
      bitcnt <= 4'h0;
      byte_n <= 2'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      sda_oe_n <= 1'b1;
      rb.wr <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      rb.wr <= 1'b0;
      if (start) begin
        st <= FDR_I2C_RX;
        bitcnt <= 4'h0;
        byte_n <= 2'h0;
        sda_oe_n <= 1'b1;
      end else if (stop) begin
        st <= FDR_I2C_IDLE;
        sda_oe_n <= 1'b1;
      end else begin
        case (st)
          FDR_I2C_RX: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              // A foreign address drops out until the next start
              if (byte_n == 2'h0 && !addr_hit) begin
                st <= FDR_I2C_IDLE;
              end else begin
                if (byte_n == 2'h0) begin
                  rd <= shreg[0];
                end else if (byte_n == 2'h1) begin
                  ptr <= shreg;
                end else begin
                  rb.wr <= 1'b1;
                end
                byte_n <= (byte_n == 2'h2) ? 2'h2 : byte_n + 2'h1;
                sda_oe_n <= 1'b0;
                st <= FDR_I2C_ACK;
              end
            end
          end
          FDR_I2C_ACK: begin
            if (scl_fall) begin
              if (rd) begin
                shreg <= rb.rdata;
                sda_oe_n <= rb.rdata[7];
                bitcnt <= 4'h1;
                st <= FDR_I2C_TX;
              end else begin
                sda_oe_n <= 1'b1;
                bitcnt <= 4'h0;
                st <= FDR_I2C_RX;
              end
            end
          end
          FDR_I2C_TX: begin
            if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                sda_oe_n <= 1'b1;
                st <= FDR_I2C_RACK;
              end else begin
                sda_oe_n <= shreg[6];
                shreg <= {shreg[6:0], 1'b0};
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          FDR_I2C_RACK: begin
            // Master NACK ends the read; ACK reloads on the next falling edge
            if (scl_rise) begin
              st <= sda ? FDR_I2C_IDLE : FDR_I2C_ACK;
            end
          end
          default: begin
            st <= FDR_I2C_IDLE;
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// file: src/fdr_tick_div.sv
// Divider producing a one-cycle pulse every CYCLES clocks.
// Restart realigns the period to the start of a flash.
`timescale 1ns/1ns
`include "fdr_defines.svh"
module fdr_tick_div
  import fdr_pkg::*;
#(
  parameter int CYCLES = `FDR_TICK_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic restart,
  output logic      tick
);
  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;

  logic [CW-1:0] cnt;
  wire           last = (cnt == CW'(CYCLES - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= (restart || last) ? '0 : cnt + 1'b1;
      tick <= last && !restart;
    end
  end
endmodule
